/* src/addr_data_mux.sv */
// Memory address, write data and read data multiplexing path
//
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
module addr_data_mux (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [addr_data_mux_pkg::HOST_AW-1:0] unibus_addr_in,
  input wire logic [addr_data_mux_pkg::HOST_AW-1:0] fast_addr_in,
  input wire logic unibus_request,
  input wire logic fast_bus_request,
  input wire logic refresh_request,
  input wire logic req_latch_pulse,
  input wire logic access_done,
  input wire logic [addr_data_mux_pkg::DATA_W-1:0] unibus_data_in,
  input wire logic [addr_data_mux_pkg::DATA_W-1:0] fast_data_in,
  input wire logic write_data_latch,
  input wire logic byte_write,
  input wire logic byte_high,
  input wire logic [addr_data_mux_pkg::WORD_W-1:0] memory_sense_data,
  input wire logic read_data_capture,
  input wire logic memory_slave_sync,
  input wire logic unibus_cycle_code1,
  output logic [addr_data_mux_pkg::MAD_W-1:0] memory_address_latch,
  output logic bit12_select_unibus,
  output logic bit12_select_fast,
  output logic bit15_select_unibus,
  output logic bit15_select_fast,
  output logic unibus_addr_gate,
  output logic fast_addr_gate,
  output logic refresh_addr_gate,
  output logic [addr_data_mux_pkg::WORD_W-1:0] mem_write_data,
  output logic [1:0] parity_store,
  output logic [addr_data_mux_pkg::DATA_W-1:0] fast_read_data,
  output logic fast_data_oe_n,
  output logic [addr_data_mux_pkg::DATA_W-1:0] unibus_read_data,
  output logic unibus_data_oe_n,
  output logic [1:0] parity_error,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  import addr_data_mux_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Latch pulse edges

  logic pulse_d_reg;
  logic lead_edge;
  logic trail_edge;
  logic [1:0] ctrl_reg;
  logic mos_mode;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pulse_d_reg <= 1'b0;
    end else begin
      pulse_d_reg <= req_latch_pulse;
    end
  end

  assign lead_edge = req_latch_pulse & ~pulse_d_reg;
  assign trail_edge = ~req_latch_pulse & pulse_d_reg;
  assign mos_mode = ctrl_reg[CTRL_MOS_BIT];

  //////////////////////////////////////////////////////////////////////////
  // Source selection and lockout

  src_state_t src_reg;
  src_state_t src_next;

  always_comb begin
    src_next = src_reg;
    unique case (src_reg)
      st_idle: begin
        // In MOS mode refresh wins a tie so rows are never starved
        if (lead_edge) begin
          if (refresh_request && mos_mode) begin
            src_next = st_refresh;
          end else if (unibus_request) begin
            src_next = st_unibus;
          end else if (fast_bus_request) begin
            src_next = st_fast;
          end
        end
      end
      st_unibus, st_fast, st_refresh: begin
        // Further pulses are ignored until the access finishes
        if (access_done) begin
          src_next = st_idle;
        end
      end
      default: begin
        src_next = st_idle;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      src_reg <= st_idle;
    end else begin
      src_reg <= src_next;
    end
  end

  // Selection is taken at the leading edge, so gates open one cycle later
  // and the source stays fixed through the capture cycle.
  assign unibus_addr_gate = (src_reg == st_unibus) & req_latch_pulse;
  assign fast_addr_gate = (src_reg == st_fast) & req_latch_pulse
    & ~unibus_request & ~refresh_request;
  assign refresh_addr_gate = (src_reg == st_refresh) & req_latch_pulse
    & refresh_request & mos_mode;

  //////////////////////////////////////////////////////////////////////////
  // Address mapping

  function automatic logic [MAD_W-1:0] map_host(
    input logic [HOST_AW-1:0] a
  );
    logic [MAD_W-1:0] m;
    m = '0;
    m[0] = a[0];
    m[11:1] = a[12:2];
    m[12] = a[1];
    m[14:13] = a[14:13];
    return m;
  endfunction : map_host

  logic [ROW_W-1:0] row_reg;
  logic [MAD_W-1:0] refresh_map;

  always_comb begin
    refresh_map = '0;
    refresh_map[ROW_LSB +: ROW_W] = row_reg;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      memory_address_latch <= MAD_RESET;
    end else if (unibus_addr_gate) begin
      memory_address_latch <= map_host(unibus_addr_in);
    end else if (fast_addr_gate) begin
      memory_address_latch <= map_host(fast_addr_in);
    end else if (refresh_addr_gate) begin
      memory_address_latch <= refresh_map;
    end
  end

  // Bit 12 and bit 15 selects travel with the captured address
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bit12_select_unibus <= 1'b0;
      bit15_select_unibus <= 1'b0;
      bit12_select_fast <= 1'b0;
      bit15_select_fast <= 1'b0;
    end else begin
      if (unibus_addr_gate) begin
        bit12_select_unibus <= unibus_addr_in[1];
        bit15_select_unibus <= unibus_addr_in[15];
      end
      if (fast_addr_gate) begin
        bit12_select_fast <= fast_addr_in[1];
        bit15_select_fast <= fast_addr_in[15];
      end
    end
  end

  // Row counter steps after each refresh capture; frozen for bipolar
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      row_reg <= ROW_RESET;
    end else if (trail_edge && src_reg == st_refresh && mos_mode) begin
      row_reg <= row_reg + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Write data path

  logic [DATA_W-1:0] wd_mux;
  logic [1:0] wd_par;
  logic store_hi;
  logic store_lo;

  assign wd_mux = fast_bus_request ? fast_data_in : unibus_data_in;
  assign wd_par = {^wd_mux[15:8], ^wd_mux[7:0]};
  assign store_hi = ~byte_write | byte_high;
  assign store_lo = ~byte_write | ~byte_high;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mem_write_data <= '0;
      parity_store <= 2'h0;
    end else if (!write_data_latch) begin
      mem_write_data[DATA_W-1:0] <= wd_mux;
      parity_store <= {store_hi, store_lo};
      if (store_hi) begin
        mem_write_data[17] <= wd_par[1];
      end
      if (store_lo) begin
        mem_write_data[16] <= wd_par[0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read data path

  logic cap_d_reg;
  logic [WORD_W-1:0] dout_n_reg;
  logic [DATA_W-1:0] dout_true;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cap_d_reg <= 1'b0;
    end else begin
      cap_d_reg <= read_data_capture;
    end
  end

  // Stored inverted, as the latching stage did; restored on the way out
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      dout_n_reg <= '1;
    end else if (read_data_capture && !cap_d_reg) begin
      dout_n_reg <= ~memory_sense_data;
    end
  end

  assign dout_true = ~dout_n_reg[DATA_W-1:0];
  assign fast_read_data = fast_bus_request ? dout_true : '0;
  assign fast_data_oe_n = ~fast_bus_request;

  // Unibus path skips the register; only the data lanes leave here
  assign unibus_read_data = memory_sense_data[DATA_W-1:0];
  assign unibus_data_oe_n = ~(memory_slave_sync & ~unibus_cycle_code1);

  // Even parity per byte: a set bit flags a bad byte
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      parity_error <= 2'h0;
    end else if (ctrl_reg[CTRL_PCHK_BIT]) begin
      parity_error[1] <= ^{~dout_n_reg[17], dout_true[15:8]};
      parity_error[0] <= ^{~dout_n_reg[16], dout_true[7:0]};
    end else begin
      parity_error <= 2'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register slave: one wait state on every access

  logic ack_reg;
  logic bus_req;
  logic [31:0] rd_next;

  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_reg;

  always_comb begin
    rd_next = 32'h0000_0000;
    unique case (avs_address)
      CTRL_OFFSET: rd_next[1:0] = ctrl_reg;
      STATUS_OFFSET: begin
        rd_next[STAT_SRC_LSB +: 4] = src_reg;
        rd_next[STAT_PERR_LSB +: 2] = parity_error;
        rd_next[STAT_ROW_LSB +: ROW_W] = row_reg;
      end
      ADDR_OFFSET: rd_next[MAD_W-1:0] = memory_address_latch;
      RDATA_OFFSET: rd_next[WORD_W-1:0] = ~dout_n_reg;
      default: rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
      if (avs_read && !ack_reg) begin
        avs_readdata <= rd_next;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= CTRL_RESET;
    end else if (avs_write && ack_reg && avs_address == CTRL_OFFSET) begin
      ctrl_reg <= avs_writedata[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_locked_lead;
    (src_reg != st_idle) && lead_edge;
  endsequence

  sequence s_capture_rise;
    read_data_capture && !cap_d_reg;
  endsequence

  chk_bipolar_no_refresh: assert property (
    !mos_mode |-> !refresh_addr_gate && $stable(row_reg))
    else $error("refresh active with bipolar matrices");

  chk_lockout_holds: assert property (
    (s_locked_lead and !access_done) |=> src_reg == $past(src_reg))
    else $error("locked source changed by late request");

  chk_addr_hold: assert property (
    !req_latch_pulse |=> $stable(memory_address_latch))
    else $error("address changed without latch pulse");

  // Written bit by bit so a fault in the mapping function shows up here
  chk_unibus_map: assert property (
    unibus_addr_gate |=>
      memory_address_latch[11:1] == $past(unibus_addr_in[12:2])
      && memory_address_latch[14:13] == $past(unibus_addr_in[14:13])
      && memory_address_latch[0] == $past(unibus_addr_in[0])
      && memory_address_latch[12] == $past(unibus_addr_in[1])
      && bit12_select_unibus == $past(unibus_addr_in[1])
      && bit15_select_unibus == $past(unibus_addr_in[15]))
    else $error("unibus address mapped wrongly");

  chk_fast_gate: assert property (
    fast_addr_gate |-> req_latch_pulse && !unibus_request
      && !refresh_request ##1
      memory_address_latch == map_host($past(fast_addr_in)))
    else $error("fast gate open while other request present");

  chk_refresh_row: assert property (
    refresh_addr_gate |=>
      memory_address_latch[ROW_LSB +: ROW_W] == $past(row_reg)
      && memory_address_latch[2:0] == 3'h0)
    else $error("refresh row not on bits 7 to 3");

  chk_wdata_hold: assert property (
    write_data_latch |=> $stable(mem_write_data))
    else $error("write latch moved while strobe high");

  chk_byte_parity: assert property (
    !write_data_latch && byte_write && !byte_high |=>
      $stable(mem_write_data[17]) && parity_store == 2'h1)
    else $error("low byte write touched high parity");

  chk_read_once: assert property (
    s_capture_rise ##1 read_data_capture[*2] |->
      dout_n_reg == ~$past(memory_sense_data, 2))
    else $error("read register recaptured within one pulse");

  chk_fast_drive: assert property (
    fast_bus_request |-> !fast_data_oe_n
      && fast_read_data == ~dout_n_reg[DATA_W-1:0])
    else $error("fast bus read data wrong or not driven");

  chk_unibus_drive: assert property (
    !unibus_data_oe_n |-> memory_slave_sync && !unibus_cycle_code1)
    else $error("unibus drivers on outside read sync");

  chk_one_gate: assert property (
    $onehot0({unibus_addr_gate, fast_addr_gate, refresh_addr_gate}))
    else $error("more than one address gate open");

  // Checked against the stored data, not the generator's own net
  chk_word_parity: assert property (
    !write_data_latch && !byte_write |=>
      mem_write_data[17] == ^mem_write_data[15:8]
      && mem_write_data[16] == ^mem_write_data[7:0])
    else $error("word parity bits wrong");

endmodule : addr_data_mux

/* src/addr_data_mux_pkg.sv */
// Constants, state codes and register map for the address and data mux
package addr_data_mux_pkg;
  localparam int HOST_AW = 18;
  localparam int MAD_W = 15;
  localparam int DATA_W = 16;
  localparam int WORD_W = 18;
  localparam int ROW_W = 5;
  localparam int ROW_LSB = 3;
  // Register byte offsets
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [3:0] ADDR_OFFSET = 4'h8;
  localparam logic [3:0] RDATA_OFFSET = 4'hC;
  // Control fields
  localparam int CTRL_MOS_BIT = 0;
  localparam int CTRL_PCHK_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  // Status fields
  localparam int STAT_SRC_LSB = 0;
  localparam int STAT_PERR_LSB = 4;
  localparam int STAT_ROW_LSB = 8;
  localparam logic [ROW_W-1:0] ROW_RESET = 5'h00;
  localparam logic [MAD_W-1:0] MAD_RESET = 15'h0000;
  typedef enum logic [3:0] {
    st_idle = 4'h1,
    st_unibus = 4'h2,
    st_fast = 4'h4,
    st_refresh = 4'h8
  } src_state_t;
endpackage : addr_data_mux_pkg

/* tb/mem_side_model.sv */
// Memory matrix model: one stored word, answers reads on demand
`timescale 1ns/10ps
module mem_side_model (
  input wire logic clock,
  input wire logic [17:0] wdata,
  input wire logic store,
  input wire logic drive,
  input wire logic corrupt,
  output logic [17:0] sense,
  output logic sync_out
);
  logic [17:0] word_reg = 18'h00000;
  logic [17:0] last_reg = 18'h00000;
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    if (store)
      word_reg <= wdata;
    if (drive)
      last_reg <= sense;
  end
  // Released sense lines show the inverse so stale data never matches
  assign sense = drive ? (word_reg ^ {1'b0, corrupt, 16'h0000}) : ~last_reg;
  assign sync_out = drive;
endmodule : mem_side_model

/* tb/tb.sv */
// Self-checking bench for the address and data mux
`timescale 1ns/10ps
module tb;
  import addr_data_mux_pkg::*;
  typedef struct packed {
    logic [2:0] rq;
    logic [17:0] ua;
    logic [17:0] fa;
    logic [2:0] gates;
  } addr_row_t;
  typedef struct packed {
    logic fast;
    logic bw;
    logic bh;
    logic [15:0] ud;
    logic [15:0] fd;
    logic [1:0] ps;
  } wr_row_t;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [17:0] unibus_addr_in, fast_addr_in, memory_sense_data, mem_write_data;
  logic unibus_request, fast_bus_request, refresh_request, req_latch_pulse;
  logic access_done, write_data_latch, byte_write, byte_high;
  logic [15:0] unibus_data_in, fast_data_in, fast_read_data, unibus_read_data;
  logic read_data_capture, memory_slave_sync, unibus_cycle_code1;
  logic [14:0] memory_address_latch;
  logic bit12_select_unibus, bit12_select_fast;
  logic bit15_select_unibus, bit15_select_fast;
  logic unibus_addr_gate, fast_addr_gate, refresh_addr_gate;
  logic [1:0] parity_store, parity_error;
  logic fast_data_oe_n, unibus_data_oe_n, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic store, drive, corrupt;
  logic [2:0] g;
  logic [4:0] row = 5'h00;
  logic [14:0] exp_m;
  logic [15:0] d;
  logic [1:0] p;
  int err_total = 0;
  int checks = 0;
  addr_row_t arow [7] = '{
    '{3'b010, 18'h00001, 18'h00000, 3'b010},
    '{3'b010, 18'h3F002, 18'h00000, 3'b010},
    '{3'b001, 18'h00000, 18'h07FFC, 3'b001},
    '{3'b001, 18'h00000, 18'h38001, 3'b001},
    '{3'b011, 18'h0AAAA, 18'h15555, 3'b010},
    '{3'b110, 18'h12345, 18'h00000, 3'b100},
    '{3'b100, 18'h00000, 18'h00000, 3'b100}};
  wr_row_t wrow [4] = '{
    '{1'b0, 1'b0, 1'b0, 16'h1234, 16'hFFFF, 2'b11},
    '{1'b1, 1'b1, 1'b0, 16'h0000, 16'h8001, 2'b01},
    '{1'b0, 1'b1, 1'b1, 16'h0300, 16'h0000, 2'b10},
    '{1'b1, 1'b0, 1'b0, 16'h0000, 16'hC3A5, 2'b11}};
  ////////////////////////////////////////////////////////////////////////////
  addr_data_mux dut_u (.clock, .nrst, .unibus_addr_in, .fast_addr_in,
    .unibus_request, .fast_bus_request, .refresh_request, .req_latch_pulse,
    .access_done, .unibus_data_in, .fast_data_in, .write_data_latch,
    .byte_write, .byte_high, .memory_sense_data, .read_data_capture,
    .memory_slave_sync, .unibus_cycle_code1, .memory_address_latch,
    .bit12_select_unibus, .bit12_select_fast, .bit15_select_unibus,
    .bit15_select_fast, .unibus_addr_gate, .fast_addr_gate,
    .refresh_addr_gate, .mem_write_data, .parity_store, .fast_read_data,
    .fast_data_oe_n, .unibus_read_data, .unibus_data_oe_n, .parity_error,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest);
  mem_side_model mem_u (.clock, .wdata(mem_write_data), .store, .drive,
    .corrupt, .sense(memory_sense_data), .sync_out(memory_slave_sync));
  always #50 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s mismatch", $time, what);
    end
  endtask : chk
  // Holds the request until waitrequest is sampled low at a rising edge
  task automatic bus(input logic rdn, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_read <= rdn;
    avs_write <= !rdn;
    avs_writedata <= wd;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && n < 20) begin
      @(posedge clock);
      n++;
    end
    if (n == 20)
      chk(0, 1, "bus wait");
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Let the release be seen before any following request
    @(posedge clock);
  endtask : bus
  task automatic access(input logic [2:0] rq, input logic [17:0] ua,
                        input logic [17:0] fa, output logic [2:0] gs);
    {refresh_request, unibus_request, fast_bus_request} <= rq;
    unibus_addr_in <= ua;
    fast_addr_in <= fa;
    req_latch_pulse <= 1'b1;
    tick(3);
    gs = {refresh_addr_gate, unibus_addr_gate, fast_addr_gate};
    req_latch_pulse <= 1'b0;
    tick(2);
  endtask : access
  task automatic end_access;
    access_done <= 1'b1;
    {refresh_request, unibus_request, fast_bus_request} <= 3'b000;
    tick(1);
    access_done <= 1'b0;
    tick(1);
  endtask : end_access
  function automatic logic [14:0] map_addr(input logic [17:0] a);
    return {a[14:13], a[1], a[12:2], a[0]};
  endfunction : map_addr
  task automatic summarize;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    err_total++;
    summarize();
  end
  initial begin
    {unibus_addr_in, fast_addr_in, unibus_data_in, fast_data_in} = '0;
    {unibus_request, fast_bus_request, refresh_request, req_latch_pulse} = '0;
    {access_done, byte_write, byte_high, read_data_capture} = '0;
    {unibus_cycle_code1, avs_read, avs_write, store, drive, corrupt} = '0;
    write_data_latch = 1'b1;
    avs_address = 4'h0;
    avs_writedata = 32'h00000000;
    tick(5);
    chk(memory_address_latch, MAD_RESET, "reset latch");
    chk(parity_error, 2'b00, "reset parity");
    nrst <= 1'b1;
    tick(1);
    bus(1'b1, CTRL_OFFSET, 32'h0, rd);
    chk(rd, {30'h0, CTRL_RESET}, "ctrl reset");
    bus(1'b1, 4'h2, 32'h0, rd);
    chk(rd, 32'h0, "unmapped read");
    $display("test reset done");
    foreach (arow[i]) begin
      access(arow[i].rq, arow[i].ua, arow[i].fa, g);
      chk(g, arow[i].gates, "gate");
      exp_m = map_addr(arow[i].gates[1] ? arow[i].ua : arow[i].fa);
      if (arow[i].gates[2]) begin
        exp_m = {7'h00, row, 3'h0};
        row = row + 5'h01;
      end
      chk(memory_address_latch, exp_m, "latch");
      if (arow[i].gates[1])
        chk({bit12_select_unibus, bit15_select_unibus},
            {arow[i].ua[1], arow[i].ua[15]}, "ub select");
      if (arow[i].gates[0])
        chk({bit12_select_fast, bit15_select_fast},
            {arow[i].fa[1], arow[i].fa[15]}, "fb select");
      end_access();
    end
    bus(1'b1, STATUS_OFFSET, 32'h0, rd);
    chk(rd[12:8], row, "row count");
    bus(1'b1, ADDR_OFFSET, 32'h0, rd);
    chk(rd, {17'h0, exp_m}, "addr reg");
    $display("test address rows done");
    foreach (wrow[i]) begin
      fast_bus_request <= wrow[i].fast;
      byte_write <= wrow[i].bw;
      byte_high <= wrow[i].bh;
      unibus_data_in <= wrow[i].ud;
      fast_data_in <= wrow[i].fd;
      write_data_latch <= 1'b0;
      tick(2);
      write_data_latch <= 1'b1;
      tick(2);
      d = wrow[i].fast ? wrow[i].fd : wrow[i].ud;
      p = {^d[15:8], ^d[7:0]} & wrow[i].ps;
      chk(mem_write_data[15:0], d, "write data");
      chk(parity_store, wrow[i].ps, "parity store");
      chk(mem_write_data[17:16] & wrow[i].ps, p, "parity bits");
    end
    unibus_data_in <= 16'h5A5A;
    fast_data_in <= 16'h5A5A;
    tick(2);
    chk(mem_write_data[15:0], 16'hC3A5, "write hold");
    $display("test write rows done");
    store <= 1'b1;
    tick(1);
    store <= 1'b0;
    drive <= 1'b1;
    read_data_capture <= 1'b1;
    tick(3);
    chk(fast_read_data, 16'hC3A5, "fast read");
    chk(fast_data_oe_n, 1'b0, "fast drive");
    chk(unibus_read_data, 16'hC3A5, "ub read");
    chk(unibus_data_oe_n, 1'b0, "ub drive");
    unibus_cycle_code1 <= 1'b1;
    tick(1);
    chk(unibus_data_oe_n, 1'b1, "ub write code");
    drive <= 1'b0;
    unibus_cycle_code1 <= 1'b0;
    tick(2);
    chk(unibus_data_oe_n, 1'b1, "ub no sync");
    chk(unibus_read_data, 16'h3C5A, "ub bypass");
    chk(fast_read_data, 16'hC3A5, "read once");
    fast_bus_request <= 1'b0;
    read_data_capture <= 1'b0;
    tick(1);
    chk({fast_data_oe_n, fast_read_data}, 17'h10000, "fast off");
    bus(1'b0, CTRL_OFFSET, 32'h2, rd);
    corrupt <= 1'b1;
    drive <= 1'b1;
    tick(1);
    read_data_capture <= 1'b1;
    tick(4);
    chk(parity_error, 2'b01, "parity check");
    bus(1'b1, RDATA_OFFSET, 32'h0, rd);
    chk(rd, 32'h0001_C3A5, "read register");
    $display("test read path done");
    access(3'b110, 18'h01234, 18'h00000, g);
    chk(g, 3'b010, "bipolar gate");
    chk(memory_address_latch, map_addr(18'h01234), "bipolar latch");
    access(3'b001, 18'h01234, 18'h3FFFF, g);
    // The held source keeps its gate; the fast request stays shut out
    chk(g, 3'b010, "locked gate");
    chk(memory_address_latch, map_addr(18'h01234), "locked hold");
    end_access();
    $display("test lockout done");
    nrst <= 1'b0;
    tick(2);
    chk(memory_address_latch, MAD_RESET, "mid reset latch");
    chk(parity_error, 2'b00, "mid reset parity");
    nrst <= 1'b1;
    tick(1);
    bus(1'b1, STATUS_OFFSET, 32'h0, rd);
    chk(rd, {19'h0, ROW_RESET, 4'h0, st_idle}, "mid reset status");
    bus(1'b1, CTRL_OFFSET, 32'h0, rd);
    chk(rd, {30'h0, CTRL_RESET}, "mid reset ctrl");
    $display("test mid reset done");
    summarize();
  end
endmodule : tb
